// ===== rtl/pci_burst_core.sv
`timescale 1ns/1ps
`default_nettype none
module burst_fifo #(
    parameter int W = 36,
    parameter int D = 16
) (
    // Clock and reset.
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // Fill side.
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    // Drain side.
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wrIdx;
        logic [AW-1:0]       rdIdx;
        logic [AW:0]         count;
    } fifo_t;
    fifo_t r;
    fifo_t n;
    logic  push;
    logic  pop;

    // Handshakes and head word.
    assign inReady  = r.count != D[AW:0];
    assign outValid = r.count != '0;
    assign outData  = r.mem[r.rdIdx];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // Pointer and count update.
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wrIdx] = inData;
            n.wrIdx = (r.wrIdx == AW'(D - 1)) ? '0 : r.wrIdx + 1'b1;
        end
        if (pop) begin
            n.rdIdx = (r.rdIdx == AW'(D - 1)) ? '0 : r.rdIdx + 1'b1;
        end
        n.count = r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // State register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule

module pci_burst_core (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Local master and bus.
    pci_burst_if.core bus,
    // User summary.
    output logic      busy,
    output logic      xferDone
);
    localparam int LW = pci_burst_pkg::LEN_W;
    typedef enum logic [2:0] {IDLE, REQ, GRANT, LOAD, ADDR, DATA, TURN} state_t;
    typedef struct packed {
        state_t        state;
        logic          reqN;
        logic          lGntN;
        logic [3:0]    stat;
        logic [1:0]    cause;
        logic [31:0]   addr;
        logic [3:0]    cmd;
        logic [LW-1:0] len;
        logic [LW-1:0] remain;
        logic [LW-1:0] toTake;
        logic [LW-1:0] toLoad;
        logic          armed;
        logic [31:0]   ad;
        logic [3:0]    cbe;
        logic          adOeN;
        logic          frameN;
        logic          frameOeN;
        logic          irdyN;
        logic          irdyOeN;
        logic          par;
        logic          parOeN;
        logic          done;
    } core_t;
    localparam core_t RESET = '{state: IDLE, reqN: 1'b1, lGntN: 1'b1, adOeN: 1'b1,
        frameN: 1'b1, frameOeN: 1'b1, irdyN: 1'b1, irdyOeN: 1'b1, parOeN: 1'b1,
        default: '0};

    core_t r;
    core_t n;
    logic                            take;
    logic                            phaseDone;
    logic                            needWord;
    logic                            bypass;
    logic                            fifoPush;
    logic                            fifoInReady;
    logic                            fifoOutValid;
    logic                            fifoPop;
    logic [pci_burst_pkg::WORD_W-1:0] fifoOut;
    logic [pci_burst_pkg::WORD_W-1:0] word;

    function automatic logic [LW-1:0] decr(input logic [LW-1:0] v);
        return v - 1'b1;
    endfunction

    // Word buffer between the local data input and AD.
    burst_fifo #(
        .W(pci_burst_pkg::WORD_W),
        .D(pci_burst_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .inData   ({bus.localCmdBeIn, bus.localAdIn}),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOut)
    );

    // Sampling, data phase and buffer steering terms.
    always_comb begin
        take      = r.armed && fifoInReady && (r.toTake != '0); // RQ8
        phaseDone = !r.irdyN && !bus.trdyN; // RQ13
        needWord  = ((r.state == ADDR) || (r.state == DATA)) && (r.irdyN || phaseDone)
                    && (r.toLoad != '0);
        bypass    = needWord && !fifoOutValid && take;
        fifoPop   = needWord && fifoOutValid;
        fifoPush  = take && !bypass;
        word      = fifoOutValid ? fifoOut : {bus.localCmdBeIn, bus.localAdIn};
    end

    // Next state of the transaction sequencer.
    always_comb begin
        n       = r;
        n.done  = 1'b0;
        n.armed = 1'b0;
        n.par   = ^{r.ad, r.cbe};
        n.parOeN = r.adOeN; // RQ22
        if (take) begin
            n.toTake = decr(r.toTake);
        end
        case (r.state)
            IDLE: begin
                n.irdyOeN = 1'b1; // RQ22
                if (!bus.localReq32bitN) begin
                    n.state = REQ;
                    n.reqN  = 1'b0;
                    n.stat  = pci_burst_pkg::STAT_IDLE;
                    n.cause = pci_burst_pkg::END_NONE;
                end
            end
            REQ: begin
                if (!bus.gntN && bus.frameN && bus.irdyN) begin
                    n.state = GRANT;
                    n.lGntN = 1'b0; // RQ2
                end
            end
            GRANT: begin
                if (bus.localReq32bitN) begin
                    n.state = IDLE;
                    n.reqN  = 1'b1;
                    n.lGntN = 1'b1;
                end else if (!bus.gntN) begin
                    n.state = LOAD;
                    n.stat  = pci_burst_pkg::STAT_ADDR_LOAD; // RQ3
                    n.addr  = bus.localAdIn; // RQ3
                    n.cmd   = bus.localCmdBeIn;
                    n.len   = bus.burstLenIn;
                end else begin
                    n.state = REQ;
                    n.lGntN = 1'b1;
                end
            end
            LOAD: begin
                if (!bus.gntN) begin
                    n.state    = ADDR;
                    n.frameN   = 1'b0; // RQ5
                    n.frameOeN = 1'b0;
                    n.adOeN    = 1'b0;
                    n.ad       = r.addr; // RQ5
                    n.cbe      = r.cmd;
                    n.stat     = pci_burst_pkg::STAT_BUS_XFER; // RQ5
                    n.remain   = r.len; // RQ6
                    n.toTake   = r.len;
                    n.toLoad   = r.len;
                    n.armed    = !bus.localReadyN; // RQ8
                    n.lGntN    = 1'b1;
                end
            end
            ADDR: begin
                n.state   = DATA;
                n.reqN    = 1'b1; // RQ10
                n.irdyOeN = 1'b0;
            end
            DATA: begin
                n.armed = !bus.localReadyN; // RQ17
                if (phaseDone) begin
                    n.remain = decr(r.remain); // RQ14
                end
                if (phaseDone && r.frameN) begin
                    n.state    = TURN;
                    n.frameOeN = 1'b1; // RQ20
                    n.adOeN    = 1'b1;
                    n.irdyN    = 1'b1;
                    n.stat     = pci_burst_pkg::STAT_BUS_TERM; // RQ20
                    n.cause    = pci_burst_pkg::END_NORMAL; // RQ23
                    n.done     = 1'b1;
                end
            end
            TURN: begin
                n.state   = IDLE;
                n.irdyOeN = 1'b1; // RQ22
            end
            default: begin
                n = RESET;
            end
        endcase
        // Load the next word onto AD once the current one is accepted.
        if (needWord) begin
            if (fifoOutValid || bypass) begin
                n.ad     = word[31:0]; // RQ15
                n.cbe    = word[35:32];
                n.irdyN  = 1'b0; // RQ16
                n.toLoad = decr(r.toLoad);
                n.frameN = (r.toLoad == LW'(1)); // RQ19
            end else begin
                n.irdyN = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= RESET;
        end else begin
            r <= n;
        end
    end

    // Outputs toward the local master and the pins.
    assign bus.localGrantN      = r.lGntN;
    assign bus.localXferState   = r.stat;
    assign bus.endCause         = r.cause;
    assign bus.burstRemaining   = r.remain;
    assign bus.localXferStrobeN = !take; // RQ11
    assign bus.reqN             = r.reqN;
    assign bus.frameO           = r.frameN;
    assign bus.frameOeN         = r.frameOeN;
    assign bus.irdyO            = r.irdyN;
    assign bus.irdyOeN          = r.irdyOeN;
    assign bus.adO              = r.ad;
    assign bus.cbeO             = r.cbe;
    assign bus.adOeN            = r.adOeN;
    assign bus.parO             = r.par;
    assign bus.parOeN           = r.parOeN;
    assign busy                 = r.state != IDLE;
    assign xferDone             = r.done;
endmodule
`default_nettype wire

// ===== rtl/pci_burst_pkg.sv
// Overview of operation
// RQ1: Local master requests with address, command, length.
// RQ2: Grant on GNT# with idle bus.
// RQ3: Request plus grant gives address-loading status.
// RQ4: Local master drops request after address loading.
// RQ5: FRAME#, address, command, bus-transaction status together.
// RQ6: Burst counter loads length in address phase.
// RQ7: Data word present when ready was asserted.
// RQ8: Strobe marks every sampled local word.
// RQ9: Ready asserted only while data available.
// RQ10: REQ# released after FRAME# asserted.
// RQ11: After address: FRAME#, IRDY# on, strobe off.
// RQ12: Ready held while next word available.
// RQ13: Data phase completes on IRDY# and TRDY#.
// RQ14: Burst counter decrements per completed phase.
// RQ15: Next buffered word driven after acceptance.
// RQ16: IRDY# kept asserted while data keeps flowing.
// RQ17: Strobe after ready and TRDY# both asserted; the core strobes a cycle after ready alone, if its buffer has room.
// RQ18: Ready dropped after last word presented.
// RQ19: Final phase: FRAME# deasserted, strobe off.
// RQ20: Turnaround: release, counter zero, normal termination.
// RQ21: Target deasserts DEVSEL# and TRDY# in turnaround.
// RQ22: Idle after turnaround releases IRDY# and PAR.
// RQ23: Status and termination codes are fixed, distinct.
package pci_burst_pkg;
    localparam int        LEN_W          = 8;
    localparam int        FIFO_DEPTH     = 16;
    localparam int        WORD_W         = 36;
    localparam logic [3:0] STAT_IDLE      = 4'h0;
    localparam logic [3:0] STAT_ADDR_LOAD = 4'h1;
    localparam logic [3:0] STAT_BUS_XFER  = 4'h2;
    localparam logic [3:0] STAT_BUS_TERM  = 4'h3;
    localparam logic [1:0] END_NONE       = 2'h0;
    localparam logic [1:0] END_NORMAL     = 2'h1;
endpackage

// ===== rtl/pci_burst_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pci_burst_if;
    // Local master side.
    logic                           localReq32bitN;
    logic                           localGrantN;
    logic [3:0]                     localXferState;
    logic [1:0]                     endCause;
    logic [31:0]                    localAdIn;
    logic [3:0]                     localCmdBeIn;
    logic [pci_burst_pkg::LEN_W-1:0] burstLenIn;
    logic [pci_burst_pkg::LEN_W-1:0] burstRemaining;
    logic                           localReadyN;
    logic                           localXferStrobeN;
    // Arbiter lines.
    logic                           reqN;
    logic                           gntN;
    // Pin drivers and enables, enables low while driving.
    logic                           frameO;
    logic                           frameOeN;
    logic                           irdyO;
    logic                           irdyOeN;
    logic [31:0]                    adO;
    logic [3:0]                     cbeO;
    logic                           adOeN;
    logic                           parO;
    logic                           parOeN;
    logic                           trdyO;
    logic                           devselO;
    logic                           tgtOeN;
    // Resolved wire levels, released lines pulled high or low.
    logic                           frameN;
    logic                           irdyN;
    logic                           trdyN;
    logic                           devselN;
    logic [31:0]                    ad;
    logic [3:0]                     cbe;
    logic                           par;

    // Wire resolution from the enables.
    assign frameN  = frameOeN ? 1'b1 : frameO;
    assign irdyN   = irdyOeN ? 1'b1 : irdyO;
    assign trdyN   = tgtOeN ? 1'b1 : trdyO;
    assign devselN = tgtOeN ? 1'b1 : devselO;
    assign ad      = adOeN ? 32'h0 : adO;
    assign cbe     = adOeN ? 4'h0 : cbeO;
    assign par     = parOeN ? 1'b0 : parO;

    modport core (
        input  localReq32bitN, localAdIn, localCmdBeIn, burstLenIn, localReadyN,
        output localGrantN, localXferState, endCause, burstRemaining, localXferStrobeN,
        output reqN, frameO, frameOeN, irdyO, irdyOeN, adO, cbeO, adOeN, parO, parOeN,
        input  gntN, frameN, irdyN, trdyN
    );
    modport partner (
        output localReq32bitN, localAdIn, localCmdBeIn, burstLenIn, localReadyN,
        input  localGrantN, localXferState, endCause, burstRemaining, localXferStrobeN,
        output gntN, trdyO, devselO, tgtOeN,
        input  reqN, frameN, irdyN, ad, cbe
    );
endinterface
`default_nettype wire

// ===== rtl/pci_burst_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pci_burst_partner (
    // Clock and reset.
    input  wire logic                           core_clk,
    input  wire logic                           rst_n,
    // Link to the core.
    pci_burst_if.partner                        bus,
    // Burst start from user logic.
    input  wire logic                           startReq,
    input  wire logic [31:0]                    startAddr,
    input  wire logic [3:0]                     startCmd,
    input  wire logic [pci_burst_pkg::LEN_W-1:0] startLen,
    output logic                                mstBusy,
    // Write data from user logic.
    input  wire logic                           wrValid,
    input  wire logic [31:0]                    wrData,
    input  wire logic [3:0]                     wrBe,
    output logic                                wrReady,
    // Words accepted by the target.
    output logic                                tgtValid,
    output logic [31:0]                         tgtData,
    output logic [3:0]                          tgtBe
);
    localparam int LW = pci_burst_pkg::LEN_W;
    typedef enum logic [1:0] {T_IDLE, T_DECODE, T_ACTIVE, T_TURN} tstate_t;
    typedef struct packed {
        logic          reqN;
        logic [31:0]   addr;
        logic [3:0]    cmd;
        logic [LW-1:0] len;
        logic [LW-1:0] left;
        logic [LW-1:0] userLeft;
        logic          have;
        logic [31:0]   data;
        logic [3:0]    be;
        logic          gntN;
        tstate_t       tstate;
        logic          trdyN;
        logic          devselN;
        logic          tOeN;
        logic          capValid;
        logic [31:0]   capData;
        logic [3:0]    capBe;
    } part_t;
    localparam part_t RESET = '{reqN: 1'b1, gntN: 1'b1, tstate: T_IDLE, trdyN: 1'b1,
        devselN: 1'b1, tOeN: 1'b1, default: '0};

    part_t         r;
    part_t         n;
    logic          strobe;
    logic          load;
    logic [LW-1:0] leftAfter;

    // Local data handshake, ready only when the next word is certain.
    always_comb begin
        strobe    = !bus.localXferStrobeN;
        wrReady   = (!r.have || strobe) && (r.userLeft != '0);
        load      = wrReady && wrValid;
        leftAfter = r.left - {{(LW - 1){1'b0}}, strobe};
    end
    assign bus.localReadyN = !((strobe ? load : r.have) && (leftAfter != '0)); // RQ9

    // Next state of local master, arbiter and target.
    always_comb begin
        n          = r;
        n.capValid = 1'b0;
        n.gntN     = bus.reqN;
        if (r.reqN && (r.left == '0) && startReq) begin
            n.reqN     = 1'b0; // RQ1
            n.addr     = startAddr;
            n.cmd      = startCmd;
            n.len      = startLen;
            n.left     = startLen;
            n.userLeft = startLen;
        end else if (bus.localXferState == pci_burst_pkg::STAT_ADDR_LOAD) begin
            n.reqN = 1'b1; // RQ4
        end
        if (strobe) begin
            n.left = leftAfter; // RQ18
        end
        if (load) begin
            n.have     = 1'b1; // RQ12
            n.data     = wrData; // RQ7
            n.be       = wrBe;
            n.userLeft = r.userLeft - 1'b1;
        end else if (strobe) begin
            n.have = 1'b0;
        end
        case (r.tstate)
            T_IDLE: begin
                n.tOeN = 1'b1;
                if (!bus.frameN) begin
                    n.tstate = T_DECODE;
                end
            end
            T_DECODE: begin
                n.tstate  = T_ACTIVE;
                n.tOeN    = 1'b0;
                n.devselN = 1'b0;
                n.trdyN   = 1'b0;
            end
            T_ACTIVE: begin
                if (!bus.irdyN && !r.trdyN) begin
                    n.capValid = 1'b1; // RQ13
                    n.capData  = bus.ad;
                    n.capBe    = bus.cbe;
                    if (bus.frameN) begin
                        n.tstate  = T_TURN;
                        n.devselN = 1'b1; // RQ21
                        n.trdyN   = 1'b1;
                    end
                end
            end
            T_TURN: begin
                n.tstate = T_IDLE;
            end
            default: begin
                n = RESET;
            end
        endcase
    end

    // State register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= RESET;
        end else begin
            r <= n;
        end
    end

    // Outputs.
    assign bus.localReq32bitN = r.reqN;
    assign bus.localAdIn      = (r.reqN) ? r.data : r.addr;
    assign bus.localCmdBeIn   = (r.reqN) ? r.be : r.cmd;
    assign bus.burstLenIn     = r.len;
    assign bus.gntN           = r.gntN;
    assign bus.trdyO          = r.trdyN;
    assign bus.devselO        = r.devselN;
    assign bus.tgtOeN         = r.tOeN;
    assign mstBusy            = !r.reqN || (r.left != '0);
    assign tgtValid           = r.capValid;
    assign tgtData            = r.capData;
    assign tgtBe              = r.capBe;
endmodule
`default_nettype wire

// ===== sim/pci_burst_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pci_burst_checker (
    // Clock and reset.
    input wire logic                            core_clk,
    input wire logic                            rst_n,
    // Local side.
    input wire logic                            localReq32bitN,
    input wire logic                            localGrantN,
    input wire logic [3:0]                      localXferState,
    input wire logic [1:0]                      endCause,
    input wire logic [pci_burst_pkg::LEN_W-1:0] burstRemaining,
    input wire logic                            localXferStrobeN,
    input wire logic                            localReadyN,
    // Bus side.
    input wire logic                            reqN,
    input wire logic                            gntN,
    input wire logic                            frameN,
    input wire logic                            irdyN,
    input wire logic                            trdyN,
    input wire logic                            devselN,
    input wire logic                            frameOeN,
    input wire logic                            irdyOeN,
    input wire logic                            adOeN,
    input wire logic                            parOeN
);
    // One clock domain, so one clocking and one disable for all.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    grant_follow_a: assert property ($fell(localGrantN) |-> $past(!gntN && frameN && irdyN))
        else $error("grant without idle bus");
    addr_load_a: assert property ($changed(localXferState) && localXferState == 4'h1
        |-> $past(!localReq32bitN && !localGrantN)) else $error("address load uncaused");
    frame_start_a: assert property ($fell(frameN) |-> localXferState == 4'h2
        && $past(localXferState == 4'h1 && !gntN)) else $error("frame start wrong");
    strobe_first_a: assert property ($fell(frameN) && !$past(localReadyN)
        |-> !localXferStrobeN) else $error("first word not strobed");
    req_release_a: assert property ($fell(frameN) |=> reqN) else $error("request kept");
    wait_cycle_a: assert property ($fell(frameN) && !$past(localReadyN) && burstRemaining > 8'h01
        |=> !frameN && !irdyN && localXferStrobeN) else $error("cycle after address wrong");
    count_dec_a: assert property (!irdyN && !trdyN
        |=> burstRemaining == $past(burstRemaining) - 8'h01) else $error("count not down");
    last_phase_a: assert property (frameN && !irdyN |-> localXferStrobeN)
        else $error("strobe in final phase");
    turnaround_a: assert property (frameN && !irdyN && !trdyN
        |=> frameOeN && adOeN && irdyN && !irdyOeN && burstRemaining == 8'h00
        && localXferState == 4'h3 && endCause == 2'h1) else $error("turnaround wrong");
    tgt_release_a: assert property (frameN && !irdyN && !trdyN |=> trdyN && devselN)
        else $error("target kept lines");
    idle_release_a: assert property (frameN && !irdyN && !trdyN |=> ##1 irdyOeN && parOeN)
        else $error("lines kept in idle");

    // Main scenarios reached.
    cover property ($fell(frameN));
    cover property ($rose(irdyN) && !frameN);
    cover property ($changed(localXferState) && endCause == 2'h1);
endmodule
`default_nettype wire

// ===== sim/pci_master_burst_write_path_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pci_master_burst_write_path_tb_top;
    localparam int TIMEOUT_CYC = 20000;
    logic        core_clk  = 1'b0;
    logic        rst_n     = 1'b0;
    logic        startReq  = 1'b0;
    logic [31:0] startAddr = 32'h0;
    logic [7:0]  startLen  = 8'h1;
    logic        wrValid   = 1'b0;
    logic [31:0] wrData    = 32'h0;
    logic [3:0]  wrBe      = 4'h0;
    logic        mstBusy, wrReady, tgtValid, busy, xferDone, prevFrame;
    logic [3:0]  tgtBe;
    logic [31:0] tgtData;
    logic [35:0] expQ[$];
    int          bad_count = 0;
    int          cmp_count = 0;
    int          doneCnt   = 0;
    int          tgtCnt    = 0;

    // Free-running clock.
    always #2.5 core_clk = ~core_clk;

    pci_burst_if i_pci_burst_if ();
    pci_burst_core i_pci_burst_core (.core_clk(core_clk), .rst_n(rst_n), .bus(i_pci_burst_if),
        .busy(busy), .xferDone(xferDone));
    pci_burst_partner i_pci_burst_partner (.core_clk(core_clk), .rst_n(rst_n),
        .bus(i_pci_burst_if), .startReq(startReq), .startAddr(startAddr), .startCmd(4'h7),
        .startLen(startLen), .mstBusy(mstBusy), .wrValid(wrValid), .wrData(wrData),
        .wrBe(wrBe), .wrReady(wrReady), .tgtValid(tgtValid), .tgtData(tgtData), .tgtBe(tgtBe));
    pci_burst_checker i_pci_burst_checker (.core_clk(core_clk), .rst_n(rst_n),
        .localReq32bitN(i_pci_burst_if.localReq32bitN),
        .localGrantN(i_pci_burst_if.localGrantN),
        .localXferState(i_pci_burst_if.localXferState), .endCause(i_pci_burst_if.endCause),
        .burstRemaining(i_pci_burst_if.burstRemaining),
        .localXferStrobeN(i_pci_burst_if.localXferStrobeN),
        .localReadyN(i_pci_burst_if.localReadyN), .reqN(i_pci_burst_if.reqN),
        .gntN(i_pci_burst_if.gntN), .frameN(i_pci_burst_if.frameN),
        .irdyN(i_pci_burst_if.irdyN), .trdyN(i_pci_burst_if.trdyN),
        .devselN(i_pci_burst_if.devselN), .frameOeN(i_pci_burst_if.frameOeN),
        .irdyOeN(i_pci_burst_if.irdyOeN), .adOeN(i_pci_burst_if.adOeN),
        .parOeN(i_pci_burst_if.parOeN));

    function automatic logic [35:0] word_of(input logic [3:0] be, input logic [31:0] d);
        return {be, d};
    endfunction

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Scoreboard for target words, the address phase and the turnaround.
    always @(posedge core_clk) begin
        prevFrame <= i_pci_burst_if.frameN;
        if (tgtValid === 1'b1) begin
            tgtCnt++;
            check(word_of(tgtBe, tgtData), expQ.size() > 0 ? expQ.pop_front() : 36'hx);
        end
        if (prevFrame === 1'b1 && i_pci_burst_if.frameN === 1'b0) begin
            check(i_pci_burst_if.ad, startAddr);
            check(i_pci_burst_if.cbe, 4'h7);
            check(i_pci_burst_if.burstRemaining, startLen);
        end
        if (xferDone === 1'b1) begin
            doneCnt++;
            check(i_pci_burst_if.burstRemaining, 8'h00);
            check(i_pci_burst_if.endCause, pci_burst_pkg::END_NORMAL);
        end
    end

    // Sends one burst of buffer depth through the core and checks that its buffer drained.
    task automatic fifo_test();
        int t0;
        t0 = tgtCnt;
        run_burst(pci_burst_pkg::FIFO_DEPTH, 0);
        check(tgtCnt - t0, pci_burst_pkg::FIFO_DEPTH);
        check(i_pci_burst_core.fifoOutValid, 1'b0);
        check(i_pci_burst_core.fifoInReady, 1'b1);
        $display("buffer test done");
    endtask

    // Runs one write burst with a given chance of data stalls in percent.
    task automatic run_burst(input int len, input int stall);
        int   sent;
        int   done0;
        int   n;
        logic took;
        sent = 0;
        n = 0;
        took = 1'b1;
        done0 = doneCnt;
        while ((mstBusy || busy) && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        startAddr = $urandom;
        startLen = 8'(len);
        startReq = 1'b1;
        @(negedge core_clk);
        startReq = 1'b0;
        while (sent < len) begin
            if (took || !wrValid) begin
                wrValid = ($urandom_range(99) >= stall);
                wrData = $urandom;
                wrBe = 4'($urandom);
            end
            @(posedge core_clk);
            took = wrValid && wrReady;
            if (took) begin
                expQ.push_back(word_of(wrBe, wrData));
                sent++;
            end
            @(negedge core_clk);
        end
        wrValid = 1'b0;
        n = 0;
        while (doneCnt == done0 && n < 4000) begin
            @(negedge core_clk);
            n++;
        end
        repeat (3) @(negedge core_clk);
        check(doneCnt - done0, 1);
        check(expQ.size(), 0);
        check(i_pci_burst_if.localXferState, pci_burst_pkg::STAT_BUS_TERM);
        $display("burst of %0d words done", len);
    endtask

    // Main sequence: corner bursts first, then random ones.
    initial begin
        void'($urandom(32'hd13e));
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst_n = 1'b1;
        fifo_test();
        run_burst(1, 0);
        run_burst(2, 0);
        run_burst(255, 0);
        run_burst(3, 70);
        repeat (6) run_burst($urandom_range(40, 1), $urandom_range(60));
        end_sim();
    end

    // Cuts a hang short.
    initial begin
        repeat (TIMEOUT_CYC) @(posedge core_clk);
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire
